// File: hdl/epo_pkg.sv
// package of constants for the energy pulse output block
`default_nettype none
package epo_pkg;
	// ****************************************
	// register map (word index on the plain port)
	// ****************************************
	localparam logic [3:0] ADDR_LED_CFG  = 4'h0;
	localparam logic [3:0] ADDR_DOUT_CFG = 4'h1;
	localparam logic [3:0] ADDR_LED_RATE = 4'h2;
	localparam logic [3:0] ADDR_DOUT_RATE = 4'h3;
	localparam logic [3:0] ADDR_STATUS   = 4'h4;
	// ****************************************
	// field layout of the config registers
	// ****************************************
	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_CHAN_LSB = 4;
	// ****************************************
	// values
	// ****************************************
	localparam logic [1:0]  MODE_OFF    = 2'h0;
	localparam logic [1:0]  MODE_ALARM  = 2'h1;
	localparam logic [1:0]  MODE_ENERGY = 2'h2;
	localparam logic [3:0]  CHAN_NUM    = 4'h9;
	localparam logic [23:0] RATE_MIN    = 24'h000001;
	localparam logic [23:0] RATE_MAX    = 24'h98967F;
	localparam logic [23:0] RATE_RESET  = 24'h000001;
	localparam logic [1:0]  MODE_RESET  = 2'h0;
	localparam logic [3:0]  CHAN_RESET  = 4'h0;
	// pulse high time
	localparam int PULSE_NS     = 1000;
	localparam int CLK_NS       = 100;
	localparam int PULSE_CYCLES = (PULSE_NS + CLK_NS - 1) / CLK_NS;
endpackage
`default_nettype wire

// File: hdl/epo_top.sv
// energy pulse output: led and digital output pulse engines with register port
//
// The placing of the registers and the strobed register port were decided locally.
`default_nettype none

// ****************************************
// one pulse channel: accumulator and pulse stretcher
// ****************************************
module epo_chan
	import epo_pkg::*;
#(
	parameter int  INC_W  = 16,
	parameter int  ACC_W  = 48,
	parameter logic [ACC_W-1:0] UNIT = 48'h00000000FFFF
) (
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic              enable,
	input  wire logic [3:0]        chan,
	input  wire logic [23:0]       rate,
	input  wire logic [INC_W-1:0]  inc_del [3],
	input  wire logic [INC_W-1:0]  inc_rec [3],
	input  wire logic              inc_valid,
	output logic                   pulse
);
	logic [ACC_W-1:0] acc_reg;
	logic [ACC_W-1:0] acc_next;
	logic [7:0]       hold_reg;
	logic [7:0]       hold_next;
	// pend counts crossings not yet shown on the pin
	logic [31:0]      pend_reg;
	logic [31:0]      pend_next;
	logic [INC_W:0]   sel_inc;
	logic [ACC_W-1:0] scaled;
	logic [1:0]       kind;
	logic [1:0]       dir;
	logic             pulse_next;

	always_comb begin
		// channel code is kind*3+dir; dir 0 delivered, 1 received, 2 both
		kind = 2'(chan / 4'h3);
		dir  = 2'(chan % 4'h3);
		sel_inc = '0;
		if (kind < 2'h3) begin
			case (dir)
				2'h0: sel_inc = {1'b0, inc_del[kind]};
				2'h1: sel_inc = {1'b0, inc_rec[kind]};
				2'h2: sel_inc = {1'b0, inc_del[kind]} + {1'b0, inc_rec[kind]};
				default: sel_inc = '0;
			endcase
		end
		// increment times rate leaves headroom in ACC_W, so the product cannot wrap
		// scale so one pulse per unit/rate: acc counts unit*rate per kWh
		scaled = ACC_W'(sel_inc) * ACC_W'(rate);
		acc_next  = acc_reg;
		pend_next = pend_reg;
		hold_next = hold_reg;
		// leaving energy mode drops the remainder so a re-enable starts clean
		if (!enable) begin
			acc_next  = '0;
			pend_next = '0;
			hold_next = '0;
		end else begin
			if (inc_valid) begin
				acc_next = acc_reg + scaled;
			end
			// one pulse per unit crossing, remainder kept
			// a big increment leaves several units behind; they drain one per clock
			if (acc_next >= UNIT) begin
				acc_next  = acc_next - UNIT;
				pend_next = pend_reg + 32'h1;
			end
			if (hold_reg != 8'h0) begin
				hold_next = hold_reg - 8'h1;
			end else if (pend_next != 32'h0) begin
				pend_next = pend_next - 32'h1;
				hold_next = 8'(2 * PULSE_CYCLES);
			end
		end
		// high for the first half of the hold window, low for the rest
		pulse_next = (hold_next > 8'(PULSE_CYCLES));
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			acc_reg  <= '0;
			pend_reg <= '0;
			hold_reg <= '0;
			pulse    <= 1'b0;
		end else begin
			acc_reg  <= acc_next;
			pend_reg <= pend_next;
			hold_reg <= hold_next;
			pulse    <= pulse_next;
		end
	end
endmodule

// ****************************************
// top
// ****************************************
module epo_top
	import epo_pkg::*;
#(
	parameter int   INC_W      = 16,
	parameter logic FIXED_ENERGY = 1'b0
) (
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic [3:0]        addr,
	input  wire logic [31:0]       wdata,
	input  wire logic              wr,
	input  wire logic              rd,
	output logic [31:0]            rdata,
	input  wire logic [INC_W-1:0]  inc_del [3],
	input  wire logic [INC_W-1:0]  inc_rec [3],
	input  wire logic              inc_valid,
	input  wire logic              alarm_pin,
	output logic                   led_out,
	output logic                   dout_out
);
	logic [1:0]  led_mode_reg,  led_mode_next;
	logic [3:0]  led_chan_reg,  led_chan_next;
	logic [1:0]  dout_mode_reg, dout_mode_next;
	logic [3:0]  dout_chan_reg, dout_chan_next;
	logic [23:0] led_rate_reg,  led_rate_next;
	logic [23:0] dout_rate_reg, dout_rate_next;
	logic        rej_reg,       rej_next;
	logic [31:0] rdata_next;
	// alarm pin is asynchronous; only the second flop is read by logic
	logic        alarm_s1_reg, alarm_s2_reg;
	logic        led_pulse, dout_pulse;
	logic        led_out_next, dout_out_next;
	// rate bits above 23 must be zero for a rate write to count
	logic [23:0] wrate;

	// ****************************************
	// register writes
	// ****************************************
	always_comb begin
		wrate          = wdata[23:0];
		led_mode_next  = led_mode_reg;
		led_chan_next  = led_chan_reg;
		dout_mode_next = dout_mode_reg;
		dout_chan_next = dout_chan_reg;
		led_rate_next  = led_rate_reg;
		dout_rate_next = dout_rate_reg;
		rej_next       = rej_reg;
		if (wr) begin
			case (addr)
				ADDR_LED_CFG: begin
					if (wdata[CFG_MODE_LSB+:2] <= MODE_ENERGY) begin
						led_mode_next = wdata[CFG_MODE_LSB+:2];
					end
					// a channel code past the last source is ignored
					if (wdata[CFG_CHAN_LSB+:4] < CHAN_NUM) begin
						led_chan_next = wdata[CFG_CHAN_LSB+:4];
					end
				end
				ADDR_DOUT_CFG: begin
					if (wdata[CFG_MODE_LSB+:2] == MODE_OFF
						|| wdata[CFG_MODE_LSB+:2] == MODE_ENERGY) begin
						dout_mode_next = wdata[CFG_MODE_LSB+:2];
					end
					if (wdata[CFG_CHAN_LSB+:4] < CHAN_NUM) begin
						dout_chan_next = wdata[CFG_CHAN_LSB+:4];
					end
				end
				ADDR_LED_RATE, ADDR_DOUT_RATE: begin
					// range check, sticky reject flag
					// a refused rate leaves the old value running; the flag tells software
					if (wdata[31:24] == 8'h0 && wrate >= RATE_MIN && wrate <= RATE_MAX) begin
						if (addr == ADDR_LED_RATE) begin
							led_rate_next = wrate;
						end else begin
							dout_rate_next = wrate;
						end
					end else begin
						rej_next = 1'b1;
					end
				end
				ADDR_STATUS: begin
					if (wdata[0]) begin
						rej_next = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		// fixed variants pin the led to energy
		if (FIXED_ENERGY) begin
			led_mode_next = MODE_ENERGY;
		end
	end

	// ****************************************
	// read mux
	// ****************************************
	// read data stand for one cycle only and are zero otherwise
	always_comb begin
		rdata_next = 32'h0;
		if (rd) begin
			case (addr)
				ADDR_LED_CFG:   rdata_next = {26'h0, led_chan_reg, led_mode_reg};
				ADDR_DOUT_CFG:  rdata_next = {26'h0, dout_chan_reg, dout_mode_reg};
				ADDR_LED_RATE:  rdata_next = {8'h0, led_rate_reg};
				ADDR_DOUT_RATE: rdata_next = {8'h0, dout_rate_reg};
				ADDR_STATUS:    rdata_next = {28'h0, dout_out, led_out, alarm_s2_reg, rej_reg};
				default:        rdata_next = 32'h0;
			endcase
		end
	end

	// ****************************************
	// pulse engines
	// ****************************************
	// led engine idles unless energy mode, so rate cannot act in alarm
	epo_chan #(.INC_W(INC_W)) u_led (
		.clk       (clk),
		.nrst      (nrst),
		.enable    (led_mode_reg == MODE_ENERGY),
		.chan      (led_chan_reg),
		.rate      (led_rate_reg),
		.inc_del   (inc_del),
		.inc_rec   (inc_rec),
		.inc_valid (inc_valid),
		.pulse     (led_pulse)
	);
	epo_chan #(.INC_W(INC_W)) u_dout (
		.clk       (clk),
		.nrst      (nrst),
		.enable    (dout_mode_reg == MODE_ENERGY),
		.chan      (dout_chan_reg),
		.rate      (dout_rate_reg),
		.inc_del   (inc_del),
		.inc_rec   (inc_rec),
		.inc_valid (inc_valid),
		.pulse     (dout_pulse)
	);

	// ****************************************
	// output select
	// ****************************************
	always_comb begin
		case (led_mode_reg)
			MODE_OFF:    led_out_next = 1'b0;
			MODE_ALARM:  led_out_next = alarm_s2_reg;
			MODE_ENERGY: led_out_next = led_pulse;
			default:     led_out_next = 1'b0;
		endcase
		// digital output pulses only in energy mode
		dout_out_next = (dout_mode_reg == MODE_ENERGY) && dout_pulse;
	end

	// every pin comes from a flop so no decode glitch reaches it
	always_ff @(posedge clk) begin
		if (!nrst) begin
			led_mode_reg  <= FIXED_ENERGY ? MODE_ENERGY : MODE_RESET;
			led_chan_reg  <= CHAN_RESET;
			dout_mode_reg <= MODE_RESET;
			dout_chan_reg <= CHAN_RESET;
			led_rate_reg  <= RATE_RESET;
			dout_rate_reg <= RATE_RESET;
			rej_reg       <= 1'b0;
			rdata         <= 32'h0;
			alarm_s1_reg  <= 1'b0;
			alarm_s2_reg  <= 1'b0;
			led_out       <= 1'b0;
			dout_out      <= 1'b0;
		end else begin
			led_mode_reg  <= led_mode_next;
			led_chan_reg  <= led_chan_next;
			dout_mode_reg <= dout_mode_next;
			dout_chan_reg <= dout_chan_next;
			led_rate_reg  <= led_rate_next;
			dout_rate_reg <= dout_rate_next;
			rej_reg       <= rej_next;
			rdata         <= rdata_next;
			alarm_s1_reg  <= alarm_pin;
			alarm_s2_reg  <= alarm_s1_reg;
			led_out       <= led_out_next;
			dout_out      <= dout_out_next;
		end
	end
endmodule
`default_nettype wire

// File: test/epo_counter.sv
// external pulse counter watching both outputs
`default_nettype none
module epo_counter (
	input  wire logic clk,
	input  wire logic led_out,
	input  wire logic dout_out,
	output int        led_cnt,
	output int        dout_cnt
);
	timeunit 1ns;
	timeprecision 1ns;
	logic led_q = 1'b0;
	logic dout_q = 1'b0;
	initial begin
		led_cnt = 0;
		dout_cnt = 0;
	end
	always @(posedge clk) begin
		led_q <= led_out;
		dout_q <= dout_out;
		if (led_out && !led_q)
			led_cnt <= led_cnt + 1;
		if (dout_out && !dout_q)
			dout_cnt <= dout_cnt + 1;
	end
endmodule
`default_nettype wire

// File: test/epo_properties.sv
// port checker for the energy pulse output block
`default_nettype none
module epo_properties
	import epo_pkg::*;
#(
	parameter int INC_W = 16
) (
	input wire logic             clk,
	input wire logic             nrst,
	input wire logic [3:0]       addr,
	input wire logic [31:0]      wdata,
	input wire logic             wr,
	input wire logic             rd,
	input wire logic [31:0]      rdata,
	input wire logic [INC_W-1:0] inc_del [3],
	input wire logic [INC_W-1:0] inc_rec [3],
	input wire logic             inc_valid,
	input wire logic             alarm_pin,
	input wire logic             led_out,
	input wire logic             dout_out
);
	logic [1:0] lm_reg, lm_next, dm_reg, dm_next;
	// ****************************************
	// mode shadow taken from register writes
	// ****************************************
	always_comb begin
		lm_next = lm_reg;
		dm_next = dm_reg;
		if (wr && addr == ADDR_LED_CFG && wdata[1:0] != 2'h3)
			lm_next = wdata[1:0];
		if (wr && addr == ADDR_DOUT_CFG && !wdata[0])
			dm_next = wdata[1:0];
	end
	always_ff @(posedge clk) begin
		lm_reg <= nrst ? lm_next : MODE_OFF;
		dm_reg <= nrst ? dm_next : MODE_OFF;
	end
	default clocking @(posedge clk);
	endclocking
	default disable iff (!nrst);
	// ****************************************
	// properties
	// ****************************************
	a_reset_dark: assert property (disable iff (1'b0) !nrst |=> !led_out && !dout_out)
		else $error("output active after reset");
	a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
		else $error("read data outside read cycle");
	a_led_off: assert property ((lm_reg == MODE_OFF) [*3] |-> !led_out)
		else $error("led lit while off");
	a_alarm_follow: assert property ((lm_reg == MODE_ALARM) [*5] |-> led_out == $past(alarm_pin, 3))
		else $error("led does not follow alarm");
	a_led_width: assert property ($rose(led_out) && lm_reg == MODE_ENERGY |-> led_out [*8] ##1 led_out [*2] ##1 !led_out [*8])
		else $error("led pulse shape wrong");
	a_led_cause: assert property ($rose(led_out) && lm_reg == MODE_ENERGY |-> $past(inc_valid, 2))
		else $error("led pulse without increment");
	a_dout_width: assert property ($rose(dout_out) |-> dout_out [*8] ##1 dout_out [*2] ##1 !dout_out [*8])
		else $error("dout pulse shape wrong");
	a_dout_off: assert property ((dm_reg == MODE_OFF) [*3] |-> !dout_out)
		else $error("dout active while off");
	a_reject_read: assert property (wr && addr == ADDR_LED_RATE && wdata == 32'h0 ##2 rd && addr == ADDR_STATUS |=> rdata[0])
		else $error("zero rate not flagged");
	c_led_pulse: cover property ($rose(led_out) && lm_reg == MODE_ENERGY);
	c_dout_pulse: cover property ($rose(dout_out));
	c_alarm_lit: cover property (lm_reg == MODE_ALARM && led_out);
endmodule
bind epo_top epo_properties #(.INC_W(INC_W)) u_epo_properties (.clk, .nrst, .addr, .wdata,
	.wr, .rd, .rdata, .inc_del, .inc_rec, .inc_valid, .alarm_pin, .led_out, .dout_out);
`default_nettype wire

// File: test/tb_top.sv
// testbench of the energy pulse output block
`default_nettype none
module tb_top
	import epo_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0, nrst, wr, rd, inc_valid, alarm_pin, led_out, dout_out;
	logic [3:0]  addr;
	logic [31:0] wdata, rdata;
	logic [15:0] inc_del [3], inc_rec [3];
	int          error_cnt = 0, comparisons = 0, led_cnt, dout_cnt;
	int          acc [2], expc [2] = '{0, 0}, ch [2], rate [2];
	always #50 clk = ~clk;
	epo_top u_epo_top (.clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .inc_del, .inc_rec,
		.inc_valid, .alarm_pin, .led_out, .dout_out);
	epo_counter u_epo_counter (.clk, .led_out, .dout_out, .led_cnt, .dout_cnt);
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, e);
		@(posedge clk);
	endtask
	// model: selected increment times rate, one pulse per unit crossed
	task automatic feed(input int n);
		int v;
		repeat (n) begin
			@(posedge clk);
			for (int i = 0; i < 3; i++) begin
				inc_del[i] <= 16'($urandom_range(8191));
				inc_rec[i] <= 16'($urandom_range(8191));
			end
			inc_valid <= 1'b1;
			@(posedge clk);
			inc_valid <= 1'b0;
			for (int k = 0; k < 2; k++) begin
				v = (ch[k] % 3 != 1 ? int'(inc_del[ch[k] / 3]) : 0);
				v += (ch[k] % 3 != 0 ? int'(inc_rec[ch[k] / 3]) : 0);
				acc[k] += v * rate[k];
				if (acc[k] >= 65535) begin
					acc[k] -= 65535;
					expc[k]++;
				end
			end
			repeat (22) @(posedge clk);
		end
	endtask
	initial begin
		repeat (100000) @(posedge clk);
		error_cnt++;
		finish_test();
	end
	initial begin
		{nrst, wr, rd, inc_valid, alarm_pin, addr, wdata} = '0;
		inc_del = '{default: '0};
		inc_rec = '{default: '0};
		void'($urandom(73284));
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		for (int a = 0; a < 5; a++) rd_chk(4'(a), 32'(a == 2 || a == 3));
		alarm_pin <= 1'b1;
		repeat (5) @(posedge clk);
		#1 chk(32'({led_out, dout_out}), 32'h0);
		rd_chk(ADDR_STATUS, 32'h2);
		alarm_pin <= 1'b0;
		$display("reset and off test done");
		// rejected rates leave the old value and raise the flag until cleared
		foreach (ch[k]) begin
			wr_reg(ADDR_LED_RATE, k ? 32'h00989680 : 32'h0);
			rd_chk(ADDR_STATUS, 32'h1);
			wr_reg(ADDR_STATUS, 32'h1);
			rd_chk(ADDR_STATUS, 32'h0);
		end
		rd_chk(ADDR_LED_RATE, 32'h1);
		wr_reg(ADDR_LED_RATE, 32'h0098967F);
		rd_chk(ADDR_LED_RATE, 32'h0098967F);
		$display("rate test done");
		wr_reg(ADDR_LED_CFG, 32'(MODE_ALARM));
		wr_reg(ADDR_LED_RATE, 32'h5);
		// large increments while in alarm must not disturb the led
		inc_del <= '{default: 16'hFFFF};
		inc_rec <= '{default: 16'hFFFF};
		inc_valid <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			alarm_pin <= i[0];
			expc[0] += int'(i[0]);
			repeat (5) @(posedge clk);
			#1 chk(32'(led_out), 32'(i[0]));
			@(posedge clk);
		end
		alarm_pin <= 1'b0;
		inc_valid <= 1'b0;
		chk(32'(led_cnt), 32'(expc[0]));
		$display("alarm test done");
		for (int c = 0; c < 9; c++) begin
			ch[0] = c;
			ch[1] = 8 - c;
			for (int k = 0; k < 2; k++) begin
				rate[k] = $urandom_range(3, 1);
				acc[k] = 0;
				wr_reg(ADDR_LED_CFG + 4'(k), 32'h0);
				wr_reg(ADDR_LED_RATE + 4'(k), 32'(rate[k]));
				wr_reg(ADDR_LED_CFG + 4'(k), 32'(ch[k] << CFG_CHAN_LSB) | 32'(MODE_ENERGY));
			end
			feed(12);
			chk(32'(led_cnt), 32'(expc[0]));
			chk(32'(dout_cnt), 32'(expc[1]));
		end
		$display("energy test done");
		finish_test();
	end
endmodule
`default_nettype wire
